/* rtl/xexec_core.sv */
// extended instruction executor with avalon-mm control and memory ports
//
// Contract
// [RULE1] nonzero skip reads the byte, writes it back, skips when not 0.
// [RULE2] a taken skip adds a dummy cycle: three cycles in total.
// [RULE3] subtract to accumulator stores accumulator minus byte there.
// [RULE4] subtract to memory writes the difference back, accumulator kept.
// [RULE5] subtract clears carry on negative result, sets it otherwise.
// [RULE6] subtract updates ov, z, ac, c, sc, cz and nothing else.
// [RULE7] in-place nibble swap exchanges the byte halves, no flags.
// [RULE8] swap to accumulator leaves the memory byte untouched.
// [RULE9] zero skip reads and writes back, skips when byte is 0, no flags.
// [RULE10] zero skip with move copies byte to accumulator, skips on zero.
// [RULE11] bit skip skips when the chosen bit is 0, no flags.
// [RULE12] paged table read uses both pointers; low to memory, high latched.
// [RULE13] last-page table read uses only the low pointer on the last page.
// [RULE14] incrementing paged read bumps the low pointer before reading.
// [RULE15] incrementing last-page read bumps the low pointer before reading.
// [RULE16] xor to accumulator stores acc xor byte, only zero flag changes.
// [RULE17] xor to memory writes acc xor byte back, only zero flag changes.
// [RULE18] sub ov, ac and sc follow two's complement; ac is bit-3 borrow (the code stores the inverted bit-3 borrow).
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "xexec_regs.svh"
module xexec_core
    import xexec_pkg::*;
#(
    parameter int DADDR_W = 8,
    parameter int PADDR_W = 16,
    parameter int PAGE_HI = 8'hFF
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // avalon-mm slave
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // data memory
    output logic [DADDR_W-1:0]      dmem_addr,
    output logic                    dmem_we,
    output logic [7:0]              dmem_wdata,
    input  wire logic [7:0]         dmem_rdata,
    // program memory
    output logic [PADDR_W-1:0]      pmem_addr,
    input  wire logic [15:0]        pmem_rdata,
    // core status
    output logic                    busy,
    output logic                    skip_next
);
    state_t               state_r, state_nxt;
    op_t                  op_r, op_nxt;
    logic [2:0]           bit_r, bit_nxt;
    logic                 busy_r, busy_nxt;
    logic [7:0]           acc_r, acc_nxt;
    flags_t               flags_r, flags_nxt;
    logic [7:0]           tlo_r, tlo_nxt;
    logic [7:0]           thi_r, thi_nxt;
    logic [7:0]           tlatch_r, tlatch_nxt;
    logic [7:0]           operand_r, operand_nxt;
    logic [15:0]          pword_r, pword_nxt;
    logic                 skip_r, skip_nxt;
    logic [1:0]           cyc_r, cyc_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic                 wait_r, wait_nxt;
    logic [DADDR_W-1:0]   daddr_r, daddr_nxt;
    logic                 dwe_r, dwe_nxt;
    logic [7:0]           dwdata_r, dwdata_nxt;
    logic [PADDR_W-1:0]   paddr_r, paddr_nxt;
    alu_out_t             sub_out;
    logic [7:0]           swapped;
    logic [7:0]           xored;
    logic                 start;

    xexec_sub8 #(
        .WIDTH      (8)
    ) u_sub (
        .minuend    (acc_r),
        .subtrahend (operand_r),
        .flags_in   (flags_r),
        .alu_out    (sub_out)
    );

    assign swapped = {operand_r[3:0], operand_r[7:4]};
    assign xored   = acc_r ^ operand_r;
    // a go request is accepted only when idle, otherwise it is held off
    assign start   = avs_write && (avs_address == `REG_CTRL)
                   && avs_writedata[`CTRL_GO_BIT] && (state_r == st_idle);

    always_comb begin
        state_nxt   = state_r;
        op_nxt      = op_r;
        bit_nxt     = bit_r;
        acc_nxt     = acc_r;
        flags_nxt   = flags_r;
        tlo_nxt     = tlo_r;
        thi_nxt     = thi_r;
        tlatch_nxt  = tlatch_r;
        operand_nxt = operand_r;
        pword_nxt   = pword_r;
        skip_nxt    = skip_r;
        cyc_nxt     = cyc_r;
        daddr_nxt   = daddr_r;
        dwe_nxt     = 1'b0;
        dwdata_nxt  = dwdata_r;
        paddr_nxt   = paddr_r;
        rdata_nxt   = rdata_r;
        wait_nxt    = 1'b1;
        // bus: a one-cycle wait, then the access completes
        if ((avs_read || avs_write) && wait_r && !(avs_write
            && avs_address == `REG_CTRL && avs_writedata[`CTRL_GO_BIT]
            && state_r != st_idle)) begin
            wait_nxt = 1'b0;
            if (avs_read) begin
                case (avs_address)
                    `REG_CTRL:      rdata_nxt = {27'h000_0000, op_r, 1'b0};
                    `REG_OPERAND:   rdata_nxt = {24'h00_0000, operand_r};
                    `REG_ACC:       rdata_nxt = {24'h00_0000, acc_r};
                    `REG_FLAGS:     rdata_nxt = {26'h000_0000, flags_r};
                    `REG_TBL_LO:    rdata_nxt = {24'h00_0000, tlo_r};
                    `REG_TBL_HI:    rdata_nxt = {24'h00_0000, thi_r};
                    `REG_TBL_LATCH: rdata_nxt = {24'h00_0000, tlatch_r};
                    `REG_STATUS:    rdata_nxt = {30'h0000_0000,
                                                 skip_r, busy_r};
                    `REG_CYCLES:    rdata_nxt = {30'h0000_0000, cyc_r};
                    default:        rdata_nxt = `UNMAPPED_READ;
                endcase
            end
        end
        // a write lands only at the edge where waitrequest is seen low
        if (avs_write && !wait_r) begin
            case (avs_address)
                `REG_CTRL: begin
                    if (start) begin
                        op_nxt    = op_t'(avs_writedata[3:0]);
                        bit_nxt   = avs_writedata[`CTRL_BIT_LSB +: 3];
                        daddr_nxt = avs_writedata[`CTRL_ADDR_LSB +: DADDR_W];
                        skip_nxt  = 1'b0;
                        cyc_nxt   = 2'd1;
                        state_nxt = st_mem_rd;
                    end
                end
                `REG_ACC:       acc_nxt = avs_writedata[7:0];
                `REG_FLAGS:     flags_nxt = flags_t'(avs_writedata[5:0]);
                `REG_TBL_LO:    tlo_nxt = avs_writedata[7:0];
                `REG_TBL_HI:    thi_nxt = avs_writedata[7:0];
                `REG_TBL_LATCH: tlatch_nxt = avs_writedata[7:0];
                default: ;
            endcase
        end
        case (state_r)
            st_idle: ;
            st_mem_rd: begin
                operand_nxt = dmem_rdata;
                case (op_r)
                    paged_table_read: begin
                        paddr_nxt = PADDR_W'({thi_r, tlo_r}); // see [RULE12]
                        state_nxt = st_prog_rd;
                    end
                    last_page_table_read: begin
                        paddr_nxt = PADDR_W'({PAGE_HI[7:0],
                                              tlo_r}); // see [RULE13]
                        state_nxt = st_prog_rd;
                    end
                    inc_paged_table_read: begin
                        tlo_nxt   = tlo_r + 8'h01; // see [RULE14]
                        paddr_nxt = PADDR_W'({thi_r, tlo_r + 8'h01});
                        state_nxt = st_prog_rd;
                    end
                    inc_last_page_table_read: begin
                        tlo_nxt   = tlo_r + 8'h01; // see [RULE15]
                        paddr_nxt = PADDR_W'({PAGE_HI[7:0], tlo_r + 8'h01});
                        state_nxt = st_prog_rd;
                    end
                    default: state_nxt = st_exec;
                endcase
            end
            st_prog_rd: begin
                pword_nxt = pmem_rdata;
                state_nxt = st_exec;
            end
            st_exec: begin
                state_nxt = st_done;
                case (op_r)
                    skip_if_mem_nonzero: begin
                        dwe_nxt    = 1'b1; // see [RULE1]
                        dwdata_nxt = operand_r;
                        skip_nxt   = (operand_r != `ZERO_BYTE);
                    end
                    skip_if_mem_zero: begin
                        dwe_nxt    = 1'b1; // see [RULE9]
                        dwdata_nxt = operand_r;
                        skip_nxt   = (operand_r == `ZERO_BYTE);
                    end
                    skip_if_zero_move_acc: begin
                        acc_nxt  = operand_r; // see [RULE10]
                        skip_nxt = (operand_r == `ZERO_BYTE);
                    end
                    skip_if_bit_zero:
                        skip_nxt = ~operand_r[bit_r]; // see [RULE11]
                    sub_mem_to_acc: begin
                        acc_nxt   = sub_out.result; // see [RULE3]
                        flags_nxt = sub_out.flags; // see [RULE6]
                    end
                    sub_result_to_mem: begin
                        dwe_nxt    = 1'b1; // see [RULE4]
                        dwdata_nxt = sub_out.result;
                        flags_nxt  = sub_out.flags; // see [RULE6]
                    end
                    nibble_exchange_mem: begin
                        dwe_nxt    = 1'b1; // see [RULE7]
                        dwdata_nxt = swapped;
                    end
                    nibble_exchange_to_acc:
                        acc_nxt = swapped; // see [RULE8]
                    xor_to_acc: begin
                        acc_nxt             = xored; // see [RULE16]
                        flags_nxt.zero_flag = (xored == `ZERO_BYTE);
                    end
                    xor_to_mem: begin
                        dwe_nxt             = 1'b1; // see [RULE17]
                        dwdata_nxt          = xored;
                        flags_nxt.zero_flag = (xored == `ZERO_BYTE);
                    end
                    paged_table_read, last_page_table_read,
                    inc_paged_table_read, inc_last_page_table_read: begin
                        dwe_nxt    = 1'b1;
                        dwdata_nxt = pword_r[7:0];
                        tlatch_nxt = pword_r[15:8];
                    end
                    // spare codes must not touch memory
                    default: ;
                endcase
            end
            st_done: begin
                cyc_nxt   = skip_r ? cyc_r + 2'd1 : cyc_r;
                // a taken skip burns one more cycle fetching a dummy
                state_nxt = skip_r ? st_dummy : st_idle; // see [RULE2]
            end
            st_dummy: begin
                cyc_nxt   = 2'(`SKIP_CYCLES); // see [RULE2]
                state_nxt = st_idle;
            end
            default: state_nxt = st_idle;
        endcase
        busy_nxt    = (state_nxt != st_idle);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r   <= st_idle;
            op_r      <= skip_if_mem_nonzero;
            bit_r     <= 3'h0;
            busy_r    <= 1'b0;
            acc_r     <= `RESET_BYTE;
            flags_r   <= '0;
            tlo_r     <= `RESET_BYTE;
            thi_r     <= `RESET_BYTE;
            tlatch_r  <= `RESET_BYTE;
            operand_r <= `RESET_BYTE;
            pword_r   <= 16'h0000;
            skip_r    <= 1'b0;
            cyc_r     <= 2'd0;
            rdata_r   <= 32'h0000_0000;
            wait_r    <= 1'b1;
            daddr_r   <= '0;
            dwe_r     <= 1'b0;
            dwdata_r  <= `RESET_BYTE;
            paddr_r   <= '0;
        end else begin
            state_r   <= state_nxt;
            op_r      <= op_nxt;
            bit_r     <= bit_nxt;
            busy_r    <= busy_nxt;
            acc_r     <= acc_nxt;
            flags_r   <= flags_nxt;
            tlo_r     <= tlo_nxt;
            thi_r     <= thi_nxt;
            tlatch_r  <= tlatch_nxt;
            operand_r <= operand_nxt;
            pword_r   <= pword_nxt;
            skip_r    <= skip_nxt;
            cyc_r     <= cyc_nxt;
            rdata_r   <= rdata_nxt;
            wait_r    <= wait_nxt;
            daddr_r   <= daddr_nxt;
            dwe_r     <= dwe_nxt;
            dwdata_r  <= dwdata_nxt;
            paddr_r   <= paddr_nxt;
        end
    end

    // every output port is a flop so nothing decoded leaves the core
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign dmem_addr       = daddr_r;
    assign dmem_we         = dwe_r;
    assign dmem_wdata      = dwdata_r;
    assign pmem_addr       = paddr_r;
    assign busy            = busy_r;
    assign skip_next       = skip_r;
endmodule

/* rtl/xexec_regs.svh */
// offsets, field positions, reset values and timing counts of the executor
`ifndef XEXEC_REGS_SVH
`define XEXEC_REGS_SVH

`define CLK_PERIOD_NS      100
`define REG_CTRL           8'h00
`define REG_OPERAND        8'h04
`define REG_ACC            8'h08
`define REG_FLAGS          8'h0C
`define REG_TBL_LO         8'h10
`define REG_TBL_HI         8'h14
`define REG_TBL_LATCH      8'h18
`define REG_STATUS         8'h1C
`define REG_CYCLES         8'h20
`define CTRL_GO_BIT        31
`define CTRL_OP_LSB        0
`define CTRL_BIT_LSB       8
`define CTRL_ADDR_LSB      16
`define FLAG_C             0
`define FLAG_AC            1
`define FLAG_Z             2
`define FLAG_OV            3
`define FLAG_SC            4
`define FLAG_CZ            5
`define ZERO_BYTE          8'h00
`define RESET_BYTE         8'h00
`define SKIP_CYCLES        3
`define PLAIN_CYCLES       1
`define UNMAPPED_READ      32'hDEAD_BEEF

`endif

/* rtl/xexec_pkg.sv */
// types shared by the extended instruction executor
package xexec_pkg;

    typedef enum logic [3:0] {
        skip_if_mem_nonzero,
        sub_mem_to_acc,
        sub_result_to_mem,
        nibble_exchange_mem,
        nibble_exchange_to_acc,
        skip_if_mem_zero,
        skip_if_zero_move_acc,
        skip_if_bit_zero,
        paged_table_read,
        last_page_table_read,
        inc_paged_table_read,
        inc_last_page_table_read,
        xor_to_acc,
        xor_to_mem
    } op_t;

    typedef struct packed {
        logic compare_zero_flag;
        logic signed_compare_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } flags_t;

    typedef struct packed {
        logic [7:0] result;
        flags_t     flags;
    } alu_out_t;

    typedef enum {
        st_idle,
        st_mem_rd,
        st_prog_rd,
        st_exec,
        st_dummy,
        st_done
    } state_t;

endpackage

/* rtl/xexec_sub8.sv */
// 8-bit subtract with full status flag generation
`timescale 1ns/1ns
`include "xexec_regs.svh"
module xexec_sub8
    import xexec_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // operands
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    input  wire flags_t           flags_in,
    // result
    output alu_out_t              alu_out
);
    logic [WIDTH:0]   diff;
    logic [4:0]       low_diff;
    logic [WIDTH-1:0] res;
    logic             ovf;

    always_comb begin
        diff     = {1'b0, minuend} - {1'b0, subtrahend};
        low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        res      = diff[WIDTH-1:0];
        ovf      = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
                 & (minuend[WIDTH-1] ^ res[WIDTH-1]);
        alu_out.result = res;
        alu_out.flags  = flags_in;
        // borrow means the result went negative: carry clear    see [RULE5]
        alu_out.flags.carry_flag          = ~diff[WIDTH];
        // aux carry is the inverted borrow out of bit 3           see [RULE18]
        alu_out.flags.aux_carry_flag      = ~low_diff[4];
        alu_out.flags.overflow_flag       = ovf;
        alu_out.flags.zero_flag           = (res == `ZERO_BYTE);
        // signed compare is sign xor overflow                   see [RULE18]
        alu_out.flags.signed_compare_flag = res[WIDTH-1] ^ ovf;
        alu_out.flags.compare_zero_flag   = (res == `ZERO_BYTE);
    end
endmodule

/* verif/xexec_core_properties.sv */
// concurrent checks on the executor's memory and bus ports
`timescale 1ns/1ns
`include "xexec_regs.svh"
module xexec_core_properties
    import xexec_pkg::*;
#(
    parameter int DADDR_W = 8,
    parameter int PADDR_W = 16,
    parameter int PAGE_HI = 8'hFF
) (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               reset,
    // avalon-mm slave
    input wire logic [7:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // data memory
    input wire logic [DADDR_W-1:0] dmem_addr,
    input wire logic               dmem_we,
    input wire logic [7:0]         dmem_wdata,
    input wire logic [7:0]         dmem_rdata,
    // program memory
    input wire logic [PADDR_W-1:0] pmem_addr,
    input wire logic [15:0]        pmem_rdata,
    // core status
    input wire logic               busy,
    input wire logic               skip_next
);
    op_t  op_r;
    op_t  op_nxt;
    logic go_take;
    logic ctrl_wr;

    assign ctrl_wr = avs_write && avs_address == `REG_CTRL;
    assign go_take = ctrl_wr && !avs_waitrequest
                     && avs_writedata[`CTRL_GO_BIT];
    // the op is only known from the go write, so it is tracked here
    always_comb begin
        op_nxt = op_r;
        if (go_take) begin
            op_nxt = op_t'(avs_writedata[3:0]);
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            op_r <= skip_if_mem_nonzero;
        end else begin
            op_r <= op_nxt;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence start_s;
        $rose(busy);
    endsequence
    sequence skip_hit_s;
        dmem_we && op_r inside {skip_if_mem_nonzero, skip_if_mem_zero}
        && ((dmem_rdata == 8'h00) == (op_r == skip_if_mem_zero));
    endsequence

    chk_go_busy: assert property (go_take |-> ##[0:1] busy)
        else $error("busy did not follow go");
    chk_busy_ends: assert property (start_s |-> ##[1:12] !busy)
        else $error("instruction did not finish in time");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_we_pulse: assert property (dmem_we |=> !dmem_we)
        else $error("memory write longer than one cycle");
    chk_skip_wback: assert property (dmem_we && op_r inside
        {skip_if_mem_nonzero, skip_if_mem_zero} |-> dmem_wdata == dmem_rdata)
        else $error("skip write-back changed the byte");
    chk_swap_wback: assert property (dmem_we
        && op_r == nibble_exchange_mem
        |-> dmem_wdata == {dmem_rdata[3:0], dmem_rdata[7:4]})
        else $error("nibble swap written wrongly");
    chk_acc_nowrite: assert property (busy && op_r inside
        {sub_mem_to_acc, nibble_exchange_to_acc, skip_if_zero_move_acc,
         skip_if_bit_zero, xor_to_acc} |-> !dmem_we)
        else $error("memory written by an accumulator op");
    chk_table_low: assert property (dmem_we && op_r inside
        {paged_table_read, last_page_table_read, inc_paged_table_read,
         inc_last_page_table_read} |-> dmem_wdata == pmem_rdata[7:0])
        else $error("table low byte not written to memory");
    chk_last_page: assert property (dmem_we && op_r inside
        {last_page_table_read, inc_last_page_table_read}
        |-> pmem_addr[PADDR_W-1 -: 8] == PAGE_HI[7:0])
        else $error("last-page read left the last page");
    chk_skip_taken: assert property (skip_hit_s
        |-> ##[0:4] skip_next)
        else $error("taken skip not flagged");
    chk_skip_hold: assert property (skip_next && !busy
        && !ctrl_wr |=> skip_next)
        else $error("skip flag dropped before next go");
endmodule

bind xexec_core xexec_core_properties #(
    .DADDR_W(DADDR_W),
    .PADDR_W(PADDR_W),
    .PAGE_HI(PAGE_HI)
) chk_u (.*);

/* verif/xexec_mem_model.sv */
// behavioural data and program memory facing the executor
`timescale 1ns/1ns
module xexec_mem_model #(
    parameter int DADDR_W = 8,
    parameter int PADDR_W = 16
) (
    // clock
    input  wire logic               clk_sys,
    // data memory
    input  wire logic [DADDR_W-1:0] dmem_addr,
    input  wire logic               dmem_we,
    input  wire logic [7:0]         dmem_wdata,
    output logic [7:0]              dmem_rdata,
    // program memory
    input  wire logic [PADDR_W-1:0] pmem_addr,
    output logic [15:0]             pmem_rdata
);
    logic [7:0] mem [0:(1<<DADDR_W)-1];

    // combinational read: the executor samples while the address stands
    assign dmem_rdata = mem[dmem_addr];
    // word mixes both address bytes so a wrong page shows up in the data
    assign pmem_rdata = {pmem_addr[7:0] ^ 8'h3C,
                         pmem_addr[15:8] + pmem_addr[7:0]};
    initial begin
        for (int i = 0; i < (1 << DADDR_W); i++) begin
            mem[i] = 8'(i * 7);
        end
    end
    always @(posedge clk_sys) begin
        if (dmem_we) begin
            mem[dmem_addr] <= dmem_wdata;
        end
    end
endmodule

/* verif/tb_extended_instr_exec_subset.sv */
// self-checking bench for the extended instruction executor
`timescale 1ns/1ns
`include "xexec_regs.svh"
module tb_extended_instr_exec_subset;
    import xexec_pkg::*;
    localparam int LAST_PG = 8'hFF;
    logic        clk_sys;
    logic        reset;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  dmem_addr;
    logic        dmem_we;
    logic [7:0]  dmem_wdata;
    logic [7:0]  dmem_rdata;
    logic [15:0] pmem_addr;
    logic [15:0] pmem_rdata;
    logic        busy;
    logic        skip_next;
    logic [31:0] d;
    int          n_fail;
    int          num_checks;
    int          seed;

    xexec_core #(.PAGE_HI(LAST_PG)) dut_u (.*);
    xexec_mem_model mdl_u (.clk_sys(clk_sys), .dmem_addr(dmem_addr),
        .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
        .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));

    always #(`CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        int k;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_read      <= rd;
        avs_write     <= !rd;
        avs_writedata <= wd;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 60);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            stop_test();
        end
    endtask

    function automatic logic [15:0] pword(input logic [15:0] p);
        return {p[7:0] ^ 8'h3C, p[15:8] + p[7:0]};
    endfunction

    task automatic run_op(input op_t op, input logic [2:0] bs,
                          input logic [7:0] ad, input logic [7:0] m,
                          input logic [7:0] a, input logic [5:0] fl,
                          input logic [7:0] lo, input logic [7:0] hi);
        logic [8:0]  r;
        logic [7:0]  ea;
        logic [7:0]  em;
        logic [7:0]  el;
        logic [7:0]  elo;
        logic [7:0]  x;
        logic [5:0]  ef;
        logic [15:0] w;
        logic        sk;
        logic        ov;
        int          k;
        mdl_u.mem[ad] = m;
        bus(0, `REG_ACC, {24'h0000_00, a}, d);
        bus(0, `REG_FLAGS, {26'h0, fl}, d);
        bus(0, `REG_TBL_LO, {24'h0000_00, lo}, d);
        bus(0, `REG_TBL_HI, {24'h0000_00, hi}, d);
        bus(1, `REG_TBL_LATCH, 32'h0000_0000, d);
        el = d[7:0];
        bus(0, `REG_CTRL, {1'b1, 7'h00, ad, 5'h00, bs, 4'h0, 4'(op)}, d);
        k = 0;
        do begin
            bus(1, `REG_STATUS, 32'h0000_0000, d);
            k++;
        end while (d[0] !== 1'b0 && k < 20);
        if (d[0] !== 1'b0) begin
            n_fail++;
            stop_test();
        end
        ea = a;
        em = m;
        ef = fl;
        elo = lo;
        sk = 1'b0;
        r = {1'b0, a} - {1'b0, m};
        ov = (a[7] ^ m[7]) & (r[7] ^ a[7]);
        x = a ^ m;
        if (op == inc_paged_table_read || op == inc_last_page_table_read) begin
            elo = lo + 8'h01;
        end
        w = pword({(op == last_page_table_read ||
                    op == inc_last_page_table_read) ? LAST_PG[7:0] : hi, elo});
        case (op)
            skip_if_mem_nonzero: sk = (m != 8'h00);
            skip_if_mem_zero: sk = (m == 8'h00);
            skip_if_zero_move_acc: begin
                ea = m;
                sk = (m == 8'h00);
            end
            skip_if_bit_zero: sk = !m[bs];
            sub_mem_to_acc, sub_result_to_mem: begin
                ef = {r[7:0] == 8'h00, ov ^ r[7], ov, r[7:0] == 8'h00,
                      a[3:0] >= m[3:0], !r[8]};
                if (op == sub_mem_to_acc) ea = r[7:0];
                else em = r[7:0];
            end
            nibble_exchange_mem: em = {m[3:0], m[7:4]};
            nibble_exchange_to_acc: ea = {m[3:0], m[7:4]};
            xor_to_acc, xor_to_mem: begin
                ef[`FLAG_Z] = (x == 8'h00);
                if (op == xor_to_acc) ea = x;
                else em = x;
            end
            default: begin
                em = w[7:0];
                el = w[15:8];
            end
        endcase
        check({31'h0, d[1]}, {31'h0, sk});
        bus(1, `REG_CYCLES, 32'h0000_0000, d);
        check(d, sk ? `SKIP_CYCLES : `PLAIN_CYCLES);
        bus(1, `REG_ACC, 32'h0000_0000, d);
        check(d, {24'h0000_00, ea});
        bus(1, `REG_FLAGS, 32'h0000_0000, d);
        check(d, {26'h0, ef});
        check({24'h0000_00, mdl_u.mem[ad]}, {24'h0000_00, em});
        bus(1, `REG_TBL_LATCH, 32'h0000_0000, d);
        check(d, {24'h0000_00, el});
        bus(1, `REG_TBL_LO, 32'h0000_0000, d);
        check(d, {24'h0000_00, elo});
    endtask

    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        n_fail = 0;
        num_checks = 0;
        seed = 22311;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        bus(1, `REG_ACC, 32'h0000_0000, d);
        check(d, {24'h0000_00, `RESET_BYTE});
        // unmapped place answers with the fixed pattern
        bus(1, 8'h40, 32'h0000_0000, d);
        check(d, `UNMAPPED_READ);
        // corner operands: zero byte, signed overflow both ways, pointer wrap
        for (int i = 0; i < 14; i++) begin
            run_op(op_t'(i), 3'd0, 8'h20, 8'h00, 8'h00, 6'h3F, 8'hFF, 8'h12);
            run_op(op_t'(i), 3'd7, 8'hFF, 8'h80, 8'h7F, 6'h00, 8'h00, 8'h34);
            run_op(op_t'(i), 3'd3, 8'h01, 8'h7F, 8'h80, 6'h15, 8'hFE, 8'h56);
        end
        for (int i = 0; i < 80; i++) begin
            run_op(op_t'(($random(seed) & 32'h7FFF_FFFF) % 14),
                   3'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                   8'($random(seed)), 6'($random(seed)), 8'($random(seed)),
                   8'($random(seed)));
        end
        stop_test();
    end
endmodule
